// [logic/secl_pkg.sv]
`default_nettype none
package secl_pkg;

  // ==========================================================================
  // Timing: serial clock derived from the system clock.
  // ==========================================================================
  localparam int unsigned CLK_HZ = 100_000_000; // System clock rate.
  localparam int unsigned SCK_HZ = 7_800_000; // Highest serial clock rate.
  // Half period in system clocks, rounded up so the serial clock never runs fast.
  localparam int unsigned SCK_HALF = (CLK_HZ + 2 * SCK_HZ - 1) / (2 * SCK_HZ);

  // ==========================================================================
  // Serial memory instructions and fields.
  // ==========================================================================
  localparam logic [7:0] OP_READ = 8'h03; // Read data from memory array.
  localparam logic [7:0] OP_WRITE = 8'h02; // Write data to memory array.
  localparam logic [7:0] OP_WREN = 8'h06; // Set the memory's write latch.
  localparam logic [7:0] OP_RDSR = 8'h05; // Read the memory's status byte.
  localparam int unsigned OP_A8_POS = 3; // Instruction bit carrying address bit 8.
  localparam int unsigned WIP_POS = 0; // Status bit that is high while writing.
  localparam logic [5:0] LEN_OP = 6'h08; // Bits in an instruction alone.
  localparam logic [5:0] LEN_SHORT = 6'h10; // Instruction plus 8-bit address.
  localparam logic [5:0] LEN_LONG = 6'h18; // Instruction plus 16-bit address.
  localparam logic [5:0] LEN_BYTE = 6'h08; // One data byte on the wire.

  // ==========================================================================
  // Image layout and address width codes.
  // ==========================================================================
  localparam logic [15:0] IMG_SIG_LOC = 16'h0000; // Signature location.
  localparam logic [15:0] IMG_CNT_LOC = 16'h0002; // Byte count location.
  localparam logic [15:0] REC_BYTES = 16'h0006; // Bytes in one record.
  localparam logic [2:0] REC_LAST = 3'h5; // Index of the last record byte.
  localparam logic [1:0] AW_NONE = 2'h0; // No memory found.
  localparam logic [1:0] AW_9 = 2'h1; // Memory with 9-bit addressing.
  localparam logic [1:0] AW_16 = 2'h2; // Memory with 16-bit addressing.

  // ==========================================================================
  // Types.
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_BOOT = 4'h0, ST_SIG = 4'h1, ST_CNT = 4'h2, ST_REC = 4'h3, ST_READY = 4'h4,
    ST_WREN = 4'h5, ST_WRITE = 4'h6, ST_POLL = 4'h7, ST_READ = 4'h8
  } secl_state_t;

  typedef struct packed {logic sck; logic cs_n; logic mosi;} secl_spi_t;
  typedef struct packed {logic valid; logic [11:0] addr; logic [3:0] be;
                         logic [31:0] data;} secl_csr_wr_t;
  typedef struct packed {logic valid; logic write; logic [15:0] addr;
                         logic [7:0] data;} secl_cmd_t;
  typedef struct packed {logic [31:0] sr; logic [5:0] len;} secl_tx_t;

  typedef struct packed {
    logic [7:0] div; logic [2:0] miso_s; logic miso_f;
    secl_spi_t spi; logic active; logic pend; logic ending; logic no_rx;
    logic [31:0] txsr; logic [5:0] txn; logic [7:0] rxsr; logic [2:0] rxn;
    secl_state_t st; logic attempt; logic bidx; logic [2:0] ridx;
    logic [7:0] lo; logic [15:0] rem; logic [1:0] aw;
    secl_csr_wr_t csr; secl_cmd_t cmd; logic busy; logic done;
    logic [7:0] rd_data; logic rd_valid; logic retry;
  } secl_regs_t;

endpackage
`default_nettype wire

// [logic/secl_loader.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Divide system clock for serial memory clock.
// - After reset, read image, write config registers.
// - Signature sits at image bytes zero and one.
// - Bytes two and three hold byte count.
// - Records: address/enables pair, then four data.
// - Round odd count up to next six.
// - First signature read uses 9-bit addressing.
// - On mismatch retry signature with 16-bit addressing.
// - Second mismatch: absent, skip loading, signal done.
// - Software may write memory in either mode.
// - Speak standard serial memory instruction protocol.
// - Matched width is kept for later accesses.
// - While loading, config retry, others unsupported.
// - Byte enables active high, bit i byte i.
// - Write: enable, write, busy, poll; ignore while busy.
module secl_loader import secl_pkg::*; #(
  parameter logic [15:0] SIG_ID = 16'h5A3C // Expected signature; arbitrary value.
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic miso,
  output secl_spi_t spi,
  output secl_csr_wr_t csr_wr,
  input wire secl_cmd_t cmd,
  input wire logic aw_set,
  input wire logic [1:0] aw_val,
  output logic [1:0] addr_width,
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic load_done,
  output logic cfg_retry
);
  // ==========================================================================
  // Helpers.
  // ==========================================================================
  // Builds a left-aligned shift image for an instruction with its address.
  function automatic secl_tx_t build(input logic [7:0] op, input logic [1:0] aw,
                                     input logic [15:0] addr, input logic [7:0] data,
                                     input logic with_data);
    secl_tx_t t;
    if (aw == AW_9) begin
      t.sr = {op[7:OP_A8_POS+1], op[OP_A8_POS] | addr[8], op[OP_A8_POS-1:0],
              addr[7:0], data, 8'h00};
      t.len = with_data ? LEN_SHORT + LEN_BYTE : LEN_SHORT;
    end else begin
      t.sr = {op, addr, data};
      t.len = with_data ? LEN_LONG + LEN_BYTE : LEN_LONG;
    end
    return t;
  endfunction
  // ==========================================================================
  // State.
  // ==========================================================================
  secl_regs_t q; // All registered state.
  secl_regs_t d; // Next value of the state.
  logic tick; // Half-period enable of the serial clock.
  logic rise, fall; // Serial clock goes high, or low, in this cycle.
  logic [7:0] rx_byte; // Byte being completed by the current sample.
  logic byte_ev; // A full byte has been received.
  logic tx_end; // Last bit of a send-only instruction is clocked.
  logic [15:0] sig; // Assembled signature.
  assign tick = q.div == 8'(SCK_HALF - 1);
  assign rise = tick && q.active && !q.spi.sck;
  assign fall = tick && q.active && q.spi.sck;
  assign rx_byte = {q.rxsr[6:0], q.miso_f};
  assign byte_ev = rise && q.txn == 6'h00 && q.rxn == 3'h7;
  assign tx_end = rise && q.txn == 6'h01 && q.no_rx;
  assign sig = {rx_byte, q.lo};
  // Next-state logic: serial engine first, then the sequencer may override it.
  always_comb begin
    d = q;
    d.csr.valid = 1'b0;
    d.rd_valid = 1'b0;
    // Divider runs free so every start lines up with a clean half period.
    d.div = tick ? 8'h00 : q.div + 8'h01;
    // Three-stage input synchroniser; a change counts once stages two and three agree.
    d.miso_s = {q.miso_s[1:0], miso};
    if (q.miso_s[1] == q.miso_s[2]) d.miso_f = q.miso_s[2];
    // Mode 0 engine: sample on the rising edge, shift on the falling edge.
    if (tick && q.pend && !q.active) begin
      d.active = 1'b1;
      d.pend = 1'b0;
      d.spi.cs_n = 1'b0;
      d.spi.mosi = q.txsr[31];
      d.rxn = 3'h0;
    end else if (rise) begin
      d.spi.sck = 1'b1;
      if (q.txn != 6'h00) begin
        d.txn = q.txn - 6'h01;
      end else begin
        d.rxsr = rx_byte;
        d.rxn = q.rxn + 3'h1;
      end
    end else if (fall) begin
      d.spi.sck = 1'b0;
      if (q.ending) begin // Chip select rises with the clock low, closing the instruction.
        d.spi.cs_n = 1'b1;
        d.active = 1'b0;
        d.ending = 1'b0;
      end else if (q.txn != 6'h00) begin
        d.txsr = {q.txsr[30:0], 1'b0};
        d.spi.mosi = q.txsr[30];
      end
    end
    case (q.st) // Sequencer.
      ST_BOOT: begin
        {d.txsr, d.txn} = build(OP_READ, AW_9, IMG_SIG_LOC, 8'h00, 1'b0);
        d.no_rx = 1'b0;
        d.pend = 1'b1;
        d.st = ST_SIG;
      end
      ST_SIG: begin
        if (byte_ev && !q.bidx) begin
          d.lo = rx_byte;
          d.bidx = 1'b1;
        end else if (byte_ev) begin
          d.ending = 1'b1;
          d.bidx = 1'b0;
          if (sig == SIG_ID) begin // The width that matched serves later accesses until software sets another with aw_set.
            d.aw = q.attempt ? AW_16 : AW_9;
            {d.txsr, d.txn} = build(OP_READ, d.aw, IMG_CNT_LOC, 8'h00, 1'b0);
            d.pend = 1'b1;
            d.st = ST_CNT;
          end else if (!q.attempt) begin
            d.attempt = 1'b1;
            {d.txsr, d.txn} = build(OP_READ, AW_16, IMG_SIG_LOC, 8'h00, 1'b0);
            d.pend = 1'b1;
          end else begin
            d.aw = AW_NONE;
            d.done = 1'b1;
            d.st = ST_READY;
          end
        end
      end
      ST_CNT: begin
        if (byte_ev && !q.bidx) begin
          d.lo = rx_byte;
          d.bidx = 1'b1;
        end else if (byte_ev) begin
          d.rem = sig;
          d.ridx = 3'h0;
          if (sig == 16'h0000) begin
            d.ending = 1'b1;
            d.done = 1'b1;
            d.st = ST_READY;
          end else begin
            d.st = ST_REC; // Records follow in the same streaming read.
          end
        end
      end
      ST_REC: begin
        if (byte_ev) begin
          d.ridx = (q.ridx == REC_LAST) ? 3'h0 : q.ridx + 3'h1;
          case (q.ridx)
            3'h0: d.csr.addr[7:0] = rx_byte;
            3'h1: begin
              d.csr.be = rx_byte[7:4];
              d.csr.addr[11:8] = rx_byte[3:0];
            end
            3'h2: d.csr.data[7:0] = rx_byte;
            3'h3: d.csr.data[15:8] = rx_byte;
            3'h4: d.csr.data[23:16] = rx_byte;
            default: begin
              d.csr.data[31:24] = rx_byte;
              // A record with no byte enabled changes nothing, so no write is made.
              d.csr.valid = q.csr.be != 4'h0;
              // Subtracting whole records to zero rounds a ragged count upward.
              d.rem = (q.rem <= REC_BYTES) ? 16'h0000 : q.rem - REC_BYTES;
              if (q.rem <= REC_BYTES) begin
                d.ending = 1'b1;
                d.done = 1'b1;
                d.st = ST_READY;
              end
            end
          endcase
        end
      end
      ST_READY: begin
        // A blank memory needs its width set by software before any access.
        if (aw_set && !q.busy) d.aw = aw_val;
        if (cmd.valid && !q.busy) begin
          d.busy = 1'b1;
          d.cmd = cmd;
          d.pend = 1'b1;
          if (cmd.write) begin
            d.txsr = {OP_WREN, 24'h000000};
            d.txn = LEN_OP;
            d.no_rx = 1'b1;
            d.st = ST_WREN;
          end else begin
            {d.txsr, d.txn} = build(OP_READ, q.aw, cmd.addr, 8'h00, 1'b0);
            d.st = ST_READ;
          end
        end
      end
      ST_WREN: begin
        if (tx_end) begin
          d.ending = 1'b1;
          {d.txsr, d.txn} = build(OP_WRITE, q.aw, q.cmd.addr, q.cmd.data, 1'b1);
          d.pend = 1'b1;
          d.st = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (tx_end) begin
          d.ending = 1'b1;
          d.txsr = {OP_RDSR, 24'h000000};
          d.txn = LEN_OP;
          d.no_rx = 1'b0;
          d.pend = 1'b1;
          d.st = ST_POLL;
        end
      end
      ST_POLL: begin
        if (byte_ev) begin
          d.ending = 1'b1;
          if (!rx_byte[WIP_POS]) begin
            d.busy = 1'b0;
            d.st = ST_READY;
          end else begin
            d.txsr = {OP_RDSR, 24'h000000}; // Poll again until the write ends.
            d.txn = LEN_OP;
            d.pend = 1'b1;
          end
        end
      end
      ST_READ: begin
        if (byte_ev) begin
          d.ending = 1'b1;
          d.rd_data = rx_byte;
          d.rd_valid = 1'b1;
          d.busy = 1'b0;
          d.st = ST_READY;
        end
      end
      default: d.st = ST_BOOT;
    endcase
    d.retry = !d.done;
  end
  // State register; reset holds chip select high, the clock low and retry status on.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.spi.cs_n <= 1'b1;
      q.retry <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign spi = q.spi;
  assign csr_wr = q.csr;
  assign addr_width = q.aw;
  assign busy = q.busy;
  assign rd_data = q.rd_data;
  assign rd_valid = q.rd_valid;
  assign load_done = q.done;
  // Held until loading ends: config requests get retry status, others unsupported.
  assign cfg_retry = q.retry;
  // ==========================================================================
  // Assertions.
  // ==========================================================================
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_sck_half_period: assert property ($rose(q.spi.sck) |-> q.spi.sck [*7] ##1 !q.spi.sck)
    else $error("serial clock high time is not seven cycles");
  a_boot_read_start: assert property ($fell(q.st == ST_BOOT) |-> ##[1:8] !q.spi.cs_n)
    else $error("image read does not start after reset");
  a_sig_first_addr: assert property (q.st == ST_BOOT |=> q.txsr[23:16] == 8'h00 && !q.attempt)
    else $error("signature read does not target location zero");
  a_retry_wide: assert property (q.st == ST_SIG && byte_ev && q.bidx && sig != SIG_ID
                                 && !q.attempt |=> q.attempt && q.st == ST_SIG)
    else $error("no 16-bit retry after signature mismatch");
  a_absent_done: assert property (q.st == ST_SIG && byte_ev && q.bidx && sig != SIG_ID
                                  && q.attempt |=> load_done && addr_width == AW_NONE)
    else $error("absent memory not flagged");
  a_round_up: assert property (csr_wr.valid && q.st == ST_REC |-> q.rem != 16'h0000)
    else $error("record written beyond rounded count");
  a_retry_loading: assert property (!load_done |-> cfg_retry ##0 !busy)
    else $error("retry status not shown while loading");
  a_busy_ignore: assert property (busy && cmd.valid |=> $stable(q.cmd))
    else $error("command taken while busy");
  a_mode0_idle: assert property (spi.cs_n |-> !spi.sck) else $error("sck high when idle");
  c_load_nine: cover property (load_done && addr_width == AW_9);
  c_load_wide: cover property (load_done && addr_width == AW_16);
  c_absent: cover property (load_done && addr_width == AW_NONE);
  c_sw_write: cover property ($fell(busy) && q.st == ST_READY && q.cmd.write);
endmodule
`default_nettype wire

// [tb/secl_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Serial memory model
// ============================================================================
// Behavioural memory on the far side of the loader, mode 0 framing.
// The mode input selects 9-bit, 16-bit or no memory at all (0).
module secl_mem_model import secl_pkg::*; (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [1:0] mode,
  output logic miso
);
  logic [7:0] mem [0:65535]; // Byte array; small parts use the low 512.
  logic [31:0] sh; // Incoming bits, newest at bit 0.
  logic [7:0] op, mo, ob; // Opcode, opcode without address bit, out byte.
  logic [15:0] ptr, msk; // Byte pointer and its address mask.
  logic rd, wr, st, wel; // Reading, writing, status, write latch.
  int n, hl, bi, wip; // Bit count, header length, out bit, busy polls.
  assign msk = (mode == 2'h1) ? 16'h01FF : 16'hFFFF;

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
    {rd, wr, st, wel, miso} = 5'h00;
    {n, bi, wip} = 0;
  end

  // A new select restarts the instruction decode.
  always @(negedge cs_n) begin
    {n, bi} = 0;
  end

  // A write ends at deselect; the part then stays busy for two polls.
  always @(posedge cs_n) begin
    if (wr) wip = 2;
    if (wr) wel = 1'b0;
    {wr, rd, st} = 3'h0;
    miso = ~miso;
  end

  // Decode instruction, address and write data on rising edges.
  always @(posedge sck) begin
    if (!cs_n && mode != 2'h0 && !rd && !st) begin
      sh = {sh[30:0], mosi};
      n++;
      hl = (mode == 2'h1) ? 16 : 24;
      if (n == 8) begin
        op = sh[7:0];
        if (op == OP_WREN) wel = 1'b1;
        st = (op == OP_RDSR);
      end
      if (n == hl) begin
        mo = (mode == 2'h1) ? (op & 8'hF7) : op;
        ptr = (mode == 2'h1) ? {7'h0, op[OP_A8_POS], sh[7:0]} : sh[15:0];
        rd = (mo == OP_READ);
        wr = (mo == OP_WRITE) && wel;
      end
      if (wr && n > hl && (n - hl) % 8 == 0) begin
        mem[ptr & msk] = sh[7:0];
        ptr++;
      end
    end
  end

  // Data leaves on falling edges; an idle line toggles so it is never trusted.
  always @(negedge sck) begin
    if (!cs_n && (rd || st)) begin
      ob = st ? {6'h0, wel, wip != 0} : mem[ptr & msk];
      miso = ob[7 - bi];
      bi++;
      if (bi == 8) begin
        bi = 0;
        if (rd) ptr++;
        if (st && wip > 0) wip--;
      end
    end else begin
      miso = ~miso;
    end
  end
endmodule
`default_nettype wire

// [tb/secl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Loader testbench
// ============================================================================
module testbench import secl_pkg::*; ;
  localparam logic [15:0] SIG = 16'h5A3C; // Signature; value is arbitrary.
  logic mclk, rst, miso, aw_set, busy, rd_valid, load_done, cfg_retry;
  logic [1:0] aw_val, addr_width, mode;
  logic [7:0] rd_data;
  secl_spi_t spi;
  secl_csr_wr_t csr_wr;
  secl_cmd_t cmd;
  secl_csr_wr_t seen [$]; // Register writes seen since the last reset.
  int miscompares, n_tests, hi_n;

  secl_loader #(.SIG_ID(SIG)) dut (.mclk(mclk), .rst(rst), .miso(miso), .spi(spi),
    .csr_wr(csr_wr), .cmd(cmd), .aw_set(aw_set), .aw_val(aw_val), .addr_width(addr_width),
    .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid), .load_done(load_done),
    .cfg_retry(cfg_retry));
  secl_mem_model mem_m (.sck(spi.sck), .cs_n(spi.cs_n), .mosi(spi.mosi), .mode(mode),
    .miso(miso));

  // The clock runs at 100 MHz.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Monitors: collect register writes and time each serial high phase.
  always @(posedge mclk) begin
    if (csr_wr.valid === 1'b1) seen.push_back(csr_wr);
    if (rst) hi_n = 0;
    else if (spi.sck === 1'b1) hi_n++;
    else if (hi_n != 0) begin
      check(hi_n, SCK_HALF);
      hi_n = 0;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Bounded wait; running out ends the run.
  task automatic wait_for(ref logic s, input logic v);
    int i;
    // Look just after each edge so the value is settled, not racing the edge.
    for (i = 0; i < 30000 && s !== v; i++) begin
      @(posedge mclk);
      #1;
    end
    if (s !== v) begin
      miscompares++;
      $display("unexpected at %0t: wait ran out", $time);
      print_verdict();
    end
  endtask

  // Reset for six cycles with the chosen memory, then let the boot load run.
  task automatic boot(input logic [1:0] m);
    mode = m;
    rst = 1'b1;
    seen.delete();
    repeat (6) @(posedge mclk);
    #1 rst = 1'b0;
    check(cfg_retry, 1'b1);
    wait_for(load_done, 1'b1);
    check(cfg_retry, 1'b0);
    // One more edge lets the monitor collect the last register write.
    @(posedge mclk);
    #1;
  endtask

  // Image header and one record; record k starts at byte 4 + 6k.
  task automatic header(input logic [15:0] cnt);
    mem_m.mem[0] = SIG[7:0];
    mem_m.mem[1] = SIG[15:8];
    mem_m.mem[2] = cnt[7:0];
    mem_m.mem[3] = cnt[15:8];
  endtask

  task automatic rec(input int k, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    int b;
    b = 4 + 6 * k;
    mem_m.mem[b] = a[7:0];
    mem_m.mem[b + 1] = {be, a[11:8]};
    for (int i = 0; i < 4; i++) mem_m.mem[b + 2 + i] = d[8 * i +: 8];
  endtask

  task automatic expect_wr(input int k, input logic [11:0] a, input logic [3:0] be,
                           input logic [31:0] d);
    check({seen[k].addr, seen[k].be}, {a, be});
    check(seen[k].data, d);
  endtask

  // Software command; the loader is busy right after the taking edge.
  task automatic sw(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 cmd = '{1'b1, w, a, d};
    @(posedge mclk);
    #1 cmd = '0;
    check(busy, 1'b1);
  endtask

  // Small memory; a count of 7 rounds up to two records, a third is never read.
  task automatic s_boot9();
    header(16'h0007);
    rec(0, 12'h123, 4'hF, 32'h11223344);
    rec(1, 12'hA5C, 4'h5, 32'hCAFEBABE);
    rec(2, 12'h0FF, 4'hF, 32'h00000000);
    boot(2'h1);
    check(addr_width, AW_9);
    check(seen.size(), 2);
    expect_wr(0, 12'h123, 4'hF, 32'h11223344);
    expect_wr(1, 12'hA5C, 4'h5, 32'hCAFEBABE);
  endtask

  // Large memory found on the retry; then a write, an ignored command and a read.
  task automatic s_boot16();
    header(16'h000C);
    rec(0, 12'h004, 4'h1, 32'h000000A5);
    rec(1, 12'h008, 4'h0, 32'h12345678);
    boot(2'h2);
    check(addr_width, AW_16);
    check(seen.size(), 1);
    expect_wr(0, 12'h004, 4'h1, 32'h000000A5);
    sw(1'b1, 16'h1234, 8'hC5);
    sw(1'b1, 16'h0200, 8'h77);
    wait_for(busy, 1'b0);
    check(mem_m.mem[16'h1234], 8'hC5);
    check(mem_m.mem[16'h0200], 8'hFF);
    sw(1'b0, 16'h1234, 8'h00);
    wait_for(busy, 1'b0);
    check(rd_valid, 1'b1);
    check(rd_data, 8'hC5);
  endtask

  // No memory answers; software then names a blank small part and writes it.
  task automatic s_absent();
    boot(2'h0);
    check(addr_width, AW_NONE);
    check(seen.size(), 0);
    @(posedge mclk);
    #1 aw_set = 1'b1;
    aw_val = AW_9;
    @(posedge mclk);
    #1 aw_set = 1'b0;
    check(addr_width, AW_9);
    mode = 2'h1;
    sw(1'b1, 16'h01A5, 8'h3C);
    wait_for(busy, 1'b0);
    check(mem_m.mem[16'h01A5], 8'h3C);
  endtask

  // Main sequence.
  initial begin
    rst = 1'b1;
    cmd = '0;
    aw_set = 1'b0;
    aw_val = 2'h0;
    mode = 2'h1;
    {miscompares, n_tests, hi_n} = 0;
    // Let the memory model fill itself first, so the image is not overwritten.
    #1;
    s_boot9();
    s_boot16();
    s_absent();
    print_verdict();
  end
endmodule
`default_nettype wire
